//--- tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: APB set-up, then frame bursts from the host model.
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, play_sample, rdv;
   logic pready, pslverr, err, play_valid, keeper_enable;
   logic serial_bit_clock, frame_sync, serial_data_in;
   logic serial_data_out, serial_data_out_en;
   logic [3:0] address_offset = 4'h0;
   logic [15:0] pat = 16'hc3a5; // Seed of all six transmit stream values.
   logic [63:0] want;
   logic [31:0] rst [4] = '{tsp_pkg::RX_CFG_RST, tsp_pkg::TX_CFG_RST,
      tsp_pkg::TX_SLOT_A_RST, tsp_pkg::TX_SLOT_B_RST};
   logic [31:0] wexp [4] = '{32'h9abc_0000, 32'h9abc_1000, 32'h9abc_1200,
      32'h9abc_1234};
   int failures = 0;
   int checks = 0;
   int pulses = 0;

   // Free-running 250 MHz bus clock.
   always #2 pclk = ~pclk;

   // Counts playback sample strobes.
   always @(posedge pclk) begin
      if (play_valid === 1'b1) pulses++;
   end

   tsp_slot_port #(.CNT_W(10)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en),
      .keeper_enable(keeper_enable), .address_offset(address_offset),
      .voltage_sense_data(pat), .current_sense_data(~pat),
      .decimated_input_data({pat[7:0], pat[15:8]}),
      .battery_data(pat[15:4]), .temperature_data(pat[11:4]),
      .gain_data(~pat[7:0]), .play_sample(play_sample),
      .play_valid(play_valid)
   );

   tsp_host_model host_u (
      .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Compares one value and counts any mismatch.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Expected transmit frame, index 0 at the top bit.
   function automatic logic [63:0] tx_exp(input logic [15:0] p,
      input logic two);
      if (two) return {8'h00, p, p[15:4], 4'h0, p[11:4], ~p[7:0], p[7:0]};
      return {8'h00, p, p[15:8], 8'h00, p[11:4], ~p[7:0], p[7:0]};
   endfunction

   // Configures receive, runs three frames and checks the played sample.
   task automatic rx_run(input logic [1:0] fe, input logic [4:0] jws,
      input logic [1:0] src, input logic [3:0] l, input logic [3:0] r,
      input logic [3:0] ao, input logic [31:0] exp);
      apb(1'b1, tsp_pkg::RX_CFG_OFS, {10'h000, r, l, src, jws, 5'h01, fe});
      @(posedge pclk);
      address_offset <= ao;
      pulses = 0;
      host_u.frames(3, fe[0]);
      repeat (20) @(posedge pclk);
      check(64'(play_sample), 64'(exp));
      check(64'(pulses > 0), 64'h1);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      check(64'(keeper_enable), 64'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, 8'(k * 4), 32'h0);
         check(64'(rdv), 64'(rst[k]));
      end
      apb(1'b0, 8'h20, 32'h0);
      check(64'({err, rdv}), 64'({1'b1, 32'h0}));
      // Slots kept apart; current sense off; last stream runs off the end.
      apb(1'b1, tsp_pkg::TX_SLOT_A_OFS, 32'h0047_0041);
      apb(1'b1, tsp_pkg::TX_SLOT_B_OFS, 32'h0046_4543);
      apb(1'b1, tsp_pkg::TX_CFG_OFS, 32'h0000_0053);
      host_u.frames(2, 1'b1);
      want = tx_exp(16'hc3a5, 1'b1);
      check(64'(keeper_enable), 64'h0);
      check({host_u.rise_d[62:0], 1'b0}, {want[63:1], 1'b0});
      check({host_u.rise_e[62:0], 1'b0}, 64'h00ff_ffff_ffff_fffe);
      // Rising-edge output, no offset, zero fill, one-slot battery.
      @(posedge pclk);
      pat <= 16'h5e71;
      apb(1'b1, tsp_pkg::TX_CFG_OFS, 32'h0000_0020);
      host_u.frames(2, 1'b1);
      want = tx_exp(16'h5e71, 1'b0);
      check(64'(keeper_enable), 64'h1);
      check(host_u.fall_d, want);
      check(host_u.fall_e, 64'hffff_ffff_ffff_ffff);
      // Receive: slot 0 holds a 32-bit word, later slots hold 16-bit words.
      host_u.rx_stream = {1'b1, 32'h9abc_1234, 16'h2468, 15'h0000};
      for (int k = 0; k < 4; k++) begin
         rx_run(2'h1, {1'b0, 2'(k), 2'b10}, 2'h0, 4'h0, 4'h0, 4'h0,
            wexp[k]);
      end
      rx_run(2'h1, 5'h12, 2'h0, 4'h0, 4'h0, 4'h0, 32'h1234_0000);
      rx_run(2'h2, 5'h0a, 2'h0, 4'h0, 4'h0, 4'h0, 32'h9abc_1200);
      rx_run(2'h1, 5'h0a, 2'h0, 4'h0, 4'h0, 4'h1, 32'h0);
      rx_run(2'h1, 5'h00, 2'h0, 4'h0, 4'h0, 4'h2, 32'h2468_0000);
      rx_run(2'h1, 5'h00, 2'h1, 4'h1, 4'h2, 4'h0, 32'h1234_0000);
      rx_run(2'h1, 5'h00, 2'h2, 4'h1, 4'h2, 4'h0, 32'h2468_0000);
      rx_run(2'h1, 5'h00, 2'h3, 4'h1, 4'h2, 4'h0, 32'h1b4e_0000);
      rx_run(2'h1, 5'h00, 2'h2, 4'h1, 4'hf, 4'h0, 32'h0);
      end_sim();
   end
endmodule

//--- tsp_host_model.sv
`timescale 1ns/1ps
// Frame-master model of the host audio processor on the serial link.
module tsp_host_model (
   output logic serial_bit_clock,
   output logic frame_sync,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en
);
   // Bit for frame count c sits at position 63-c in every vector.
   logic [63:0] rx_stream;
   logic [63:0] rise_d, rise_e, fall_d, fall_e;

   // Idle link: clock low, sync at its idle level.
   initial begin
      serial_bit_clock = 1'b0;
      frame_sync = 1'b1;
      serial_data_in = 1'b0;
      rx_stream = 64'h0;
   end

   // Sends n frames of 64 bit clocks; the clock stands still otherwise.
   task automatic frames(input int n, input logic fs);
      #1.3;
      frame_sync = fs;
      #40;
      for (int f = 0; f < n; f++) begin
         for (int c = 0; c < 64; c++) begin
            #20;
            frame_sync = (c < 32) ? ~fs : fs;
            serial_data_in = rx_stream[63-c];
            #20;
            rise_d[63-c] = serial_data_out;
            rise_e[63-c] = serial_data_out_en;
            serial_bit_clock = 1'b1;
            #40;
            fall_d[63-c] = serial_data_out;
            fall_e[63-c] = serial_data_out_en;
            serial_bit_clock = 1'b0;
         end
      end
      // A released data line must not keep showing its last value.
      serial_data_in = ~serial_data_in;
   endtask
endmodule

//--- tsp_pkg.sv
// Shared constants for the TDM audio slot port.
package tsp_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] RX_CFG_OFS = 8'h00;
   localparam logic [7:0] TX_CFG_OFS = 8'h04;
   localparam logic [7:0] TX_SLOT_A_OFS = 8'h08;
   localparam logic [7:0] TX_SLOT_B_OFS = 8'h0c;
   localparam logic [7:0] RX_SAMPLE_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   // Field positions in the receive configuration register.
   localparam int RX_FSTART_POS = 0;
   localparam int RX_EDGE_POS = 1;
   localparam int RX_OFFSET_POS = 2;
   localparam int RX_SLEN_POS = 7;
   localparam int RX_WORD_LENGTH_POS = 9;
   localparam int RX_JUST_POS = 11;
   localparam int RX_SRC_POS = 12;
   localparam int RX_SLOTL_POS = 14;
   localparam int RX_SLOTR_POS = 18;
   // Field positions in the transmit configuration register.
   localparam int TX_EDGE_POS = 0;
   localparam int TX_OFFSET_POS = 1;
   localparam int TX_FILL_POS = 4;
   localparam int TX_KEEPER_POS = 5;
   localparam int TX_BATLEN_POS = 6;
   // Each slot register holds three streams of slot field plus enable.
   localparam int SLOT_FIELD_STRIDE = 8;
   localparam int SLOT_EN_POS = 6;
   // Values after reset.
   localparam logic [31:0] RX_CFG_RST = 32'h0000_0505;
   localparam logic [31:0] TX_CFG_RST = 32'h0000_0033;
   localparam logic [31:0] TX_SLOT_A_RST = 32'h0004_0200;
   localparam logic [31:0] TX_SLOT_B_RST = 32'h0008_0706;
   // Writable bits of each register; the rest read as zero.
   localparam logic [31:0] RX_CFG_MASK = 32'h003f_ffff;
   localparam logic [31:0] TX_CFG_MASK = 32'h0000_007f;
   localparam logic [31:0] TX_SLOT_MASK = 32'h007f_7f7f;
   // Transmit slots are one byte wide.
   localparam int TX_SLOT_BITS = 8;
   localparam int STREAM_COUNT = 6;
   // Playback source selections.
   typedef enum logic [1:0] {
      SRC_ADDR = 2'b00,
      SRC_LEFT = 2'b01,
      SRC_RIGHT = 2'b10,
      SRC_MIX = 2'b11
   } tsp_src_t;
endpackage

//--- tsp_slot_port.sv
// Functional notes
// - Word length codes 16/20/24/32, default 24
// - Justify bit: left default, right when set
// - Source 00 address slot, 01 left, 10 right
// - Left slot index four bits, default 0
// - Right slot index four bits, default 0
// - Transmit sense, PDM, battery, temperature, gain streams
// - Output changes on edge set by transmit-edge bit
// - Transmit offset 0 to 7, default 1
// - Unused bits drive zero or float per fill
// - Keeper enable bit, default on
// - Transmit slots are eight bits wide
// - Sense and PDM streams use two slots
// - Battery sent 16-bit justified or top byte
// - Temperature and gain use one slot
// - Slot field names upper byte slot
// - Each stream sent only when enabled
// - Transmission stops at frame boundary
// - Voltage sense slot default 0, disabled
// - Current sense slot default 2, disabled
// - Decimated Decimated_input_slot default 4
// - Frame starts on selected sync transition
// - Sync and data sampled on chosen edge
// - Receive offset 0 to 31, default 1
// - Slot beyond frame yields muted sample
`timescale 1ns/1ps
module tsp_slot_port #(
   parameter int CNT_W = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_bit_clock,
   input wire logic frame_sync,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_en,
   output logic keeper_enable,
   input wire logic [3:0] address_offset,
   input wire logic [15:0] voltage_sense_data,
   input wire logic [15:0] current_sense_data,
   input wire logic [15:0] decimated_input_data,
   input wire logic [11:0] battery_data,
   input wire logic [7:0] temperature_data,
   input wire logic [7:0] gain_data,
   output logic [31:0] play_sample,
   output logic play_valid
);
   // The bit counter must cover a 512-bit frame plus offsets.
   initial begin
      if (CNT_W < 10 || CNT_W > 16) begin
         $error("CNT_W must lie between 10 and 16");
      end
   end

   // Configuration registers written by software.
   logic [31:0] rx_cfg_q;
   logic [31:0] tx_cfg_q;
   logic [31:0] slot_a_q;
   logic [31:0] slot_b_q;
   // APB answer registers.
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   // Link synchronisers and accepted pin levels (bit 0 clock, 1 sync, 2 data).
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;
   logic [2:0] level_q;
   // Frame tracking.
   logic fs_prev_q;
   logic framed_q;
   logic [CNT_W-1:0] cnt_q;
   // Receive shift registers for the two chosen slots.
   logic [31:0] sh_a_q;
   logic [31:0] sh_b_q;
   logic [31:0] play_sample_q;
   logic play_valid_q;
   logic null_q;
   logic [7:0] frame_count_q;
   // Latched stream words, 16 bits each, upper byte first.
   logic [15:0] stream_q [tsp_pkg::STREAM_COUNT];
   // Transmit pin registers.
   logic sdo_q;
   logic sdo_en_q;
   logic keeper_q;

   // Configuration fields decoded from the registers.
   wire fstart_bit = rx_cfg_q[tsp_pkg::RX_FSTART_POS];
   wire rx_edge_bit = rx_cfg_q[tsp_pkg::RX_EDGE_POS];
   wire [4:0] rx_offset = rx_cfg_q[tsp_pkg::RX_OFFSET_POS +: 5];
   wire [1:0] rx_slot_len = rx_cfg_q[tsp_pkg::RX_SLEN_POS +: 2];
   wire [1:0] rx_word_length = rx_cfg_q[tsp_pkg::RX_WORD_LENGTH_POS +: 2];
   wire rx_justify = rx_cfg_q[tsp_pkg::RX_JUST_POS];
   wire [1:0] rx_source_config = rx_cfg_q[tsp_pkg::RX_SRC_POS +: 2];
   wire [3:0] rx_slot_left = rx_cfg_q[tsp_pkg::RX_SLOTL_POS +: 4];
   wire [3:0] rx_slot_right = rx_cfg_q[tsp_pkg::RX_SLOTR_POS +: 4];
   wire tx_edge_bit = tx_cfg_q[tsp_pkg::TX_EDGE_POS];
   wire [2:0] tx_offset = tx_cfg_q[tsp_pkg::TX_OFFSET_POS +: 3];
   wire tx_fill = tx_cfg_q[tsp_pkg::TX_FILL_POS];
   wire tx_keeper = tx_cfg_q[tsp_pkg::TX_KEEPER_POS];
   wire battery_slot_length = tx_cfg_q[tsp_pkg::TX_BATLEN_POS];

   // APB decode: setup phase, access completion and address match.
   wire apb_setup = psel && !penable;
   wire apb_done = psel && penable && pready_q;
   wire apb_wr = apb_done && pwrite;
   wire hit_rx = paddr == tsp_pkg::RX_CFG_OFS;
   wire hit_tx = paddr == tsp_pkg::TX_CFG_OFS;
   wire hit_sa = paddr == tsp_pkg::TX_SLOT_A_OFS;
   wire hit_sb = paddr == tsp_pkg::TX_SLOT_B_OFS;
   wire hit_smp = paddr == tsp_pkg::RX_SAMPLE_OFS;
   wire hit_st = paddr == tsp_pkg::STATUS_OFS;
   wire hit_any = hit_rx || hit_tx || hit_sa || hit_sb || hit_smp || hit_st;
   wire [31:0] status_w = {23'h000000, null_q, frame_count_q};
   wire [31:0] rd_mux =
      hit_rx ? rx_cfg_q :
      hit_tx ? tx_cfg_q :
      hit_sa ? slot_a_q :
      hit_sb ? slot_b_q :
      hit_smp ? play_sample_q :
      hit_st ? status_w : 32'h0000_0000;

   // The answer is prepared in the setup cycle so every access takes one
   // wait-free access cycle; unmapped addresses answer with an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup && !hit_any;
         prdata_q <= apb_setup ? rd_mux : 32'h0000_0000;
      end
   end

   // Configuration writes; reset values carry every documented default.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cfg_q <= tsp_pkg::RX_CFG_RST;
         tx_cfg_q <= tsp_pkg::TX_CFG_RST;
         slot_a_q <= tsp_pkg::TX_SLOT_A_RST;
         slot_b_q <= tsp_pkg::TX_SLOT_B_RST;
      end else if (apb_wr) begin
         if (hit_rx) begin
            rx_cfg_q <= pwdata & tsp_pkg::RX_CFG_MASK;
         end
         if (hit_tx) begin
            tx_cfg_q <= pwdata & tsp_pkg::TX_CFG_MASK;
         end
         if (hit_sa) begin
            slot_a_q <= pwdata & tsp_pkg::TX_SLOT_MASK;
         end
         if (hit_sb) begin
            slot_b_q <= pwdata & tsp_pkg::TX_SLOT_MASK;
         end
      end
   end

   // Three-stage synchronisers; a pin change is accepted once the second
   // and third stages agree on a level other than the accepted one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
         level_q <= 3'h0;
      end else begin
         sync1_q <= {serial_data_in, frame_sync, serial_bit_clock};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         level_q <= (sync2_q ~^ sync3_q) & sync3_q | ~(sync2_q ~^ sync3_q)
            & level_q;
      end
   end

   // Bit-clock edges as seen after filtering.
   wire bclk_chg = (sync2_q[0] == sync3_q[0]) && (sync3_q[0] != level_q[0]);
   wire bclk_rise = bclk_chg && sync3_q[0];
   wire bclk_fall = bclk_chg && !sync3_q[0];
   wire samp_edge = rx_edge_bit ? bclk_fall : bclk_rise;
   wire drive_edge = tx_edge_bit ? bclk_fall : bclk_rise;
   wire fs_now = sync3_q[1];
   wire din_now = sync3_q[2];
   // A frame opens on the selected sync transition at a sampling edge.
   wire frame_open = samp_edge && (fs_now != fs_prev_q) &&
      (fs_now == !fstart_bit);

   // Bit counter: zero at the sampling edge that sees the frame opening.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_prev_q <= 1'b1;
         cnt_q <= '1;
         framed_q <= 1'b0;
      end else if (samp_edge) begin
         fs_prev_q <= fs_now;
         if (frame_open) begin
            cnt_q <= '0;
            framed_q <= 1'b1;
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Slot and word lengths in bits; reserved slot code reads as 32.
   wire [5:0] slot_bits = (rx_slot_len == 2'b00) ? 6'd16 :
      (rx_slot_len == 2'b01) ? 6'd24 : 6'd32;
   wire [5:0] word_bits = (rx_word_length == 2'b00) ? 6'd16 :
      (rx_word_length == 2'b01) ? 6'd20 :
      (rx_word_length == 2'b10) ? 6'd24 : 6'd32;
   // Channel A is the mono source; channel B is the right slot for the mix.
   wire [3:0] slot_a_sel = (rx_source_config == tsp_pkg::SRC_ADDR) ?
      address_offset : (rx_source_config == tsp_pkg::SRC_RIGHT) ?
      rx_slot_right : rx_slot_left;
   wire [3:0] slot_b_sel = rx_slot_right;
   // Position of the bit sampled at this edge; the opening bit is zero.
   wire [CNT_W:0] rx_pos = frame_open ? '0 :
      (CNT_W+1)'(cnt_q) + 1'b1;

   // First bit of a slot counted from the frame opening.
   function automatic logic [CNT_W:0] slot_start(input logic [3:0] s);
      logic [CNT_W:0] prod;
      prod = (CNT_W+1)'(s) * (CNT_W+1)'(slot_bits);
      return prod + (CNT_W+1)'(rx_offset);
   endfunction

   // True when the just-sampled bit belongs to the word of slot s.
   function automatic logic in_word(input logic [3:0] s);
      logic [CNT_W:0] ws;
      logic [CNT_W:0] pos;
      ws = slot_start(s);
      pos = rx_pos;
      if (rx_justify) begin
         ws = ws + (CNT_W+1)'(slot_bits) - (CNT_W+1)'(word_bits);
      end
      return (pos >= ws) && (pos < ws + (CNT_W+1)'(word_bits));
   endfunction

   // Length of the frame now ending and the null test on the slots used.
   wire [CNT_W:0] frame_len = (CNT_W+1)'(cnt_q) + 1'b1;
   wire end_a_out = slot_start(slot_a_sel) + (CNT_W+1)'(slot_bits) >
      frame_len;
   wire end_b_out = slot_start(slot_b_sel) + (CNT_W+1)'(slot_bits) >
      frame_len;
   wire mix_mode = rx_source_config == tsp_pkg::SRC_MIX;
   wire null_w = end_a_out || (mix_mode && end_b_out);
   // Words left-aligned to 32 bits and the halved stereo sum.
   wire [5:0] pad_bits = 6'd32 - word_bits;
   wire [31:0] word_a = sh_a_q << pad_bits;
   wire [31:0] word_b = sh_b_q << pad_bits;
   wire [32:0] mix_sum = {word_a[31], word_a} + {word_b[31], word_b};
   wire [31:0] mix_half = mix_sum[32:1];
   wire [31:0] sample_w = null_w ? 32'h0000_0000 :
      mix_mode ? mix_half : word_a;

   // Receive shifting and delivery of one sample per frame.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_a_q <= 32'h0000_0000;
         sh_b_q <= 32'h0000_0000;
         play_sample_q <= 32'h0000_0000;
         play_valid_q <= 1'b0;
         null_q <= 1'b0;
         frame_count_q <= 8'h00;
      end else begin
         play_valid_q <= frame_open && framed_q;
         if (frame_open) begin
            if (framed_q) begin
               play_sample_q <= sample_w;
               null_q <= null_w;
               frame_count_q <= frame_count_q + 8'h01;
            end
            // The opening bit itself may already belong to a word.
            sh_a_q <= in_word(slot_a_sel) ? {31'h0, din_now} : 32'h0;
            sh_b_q <= in_word(slot_b_sel) ? {31'h0, din_now} : 32'h0;
         end else if (samp_edge) begin
            if (in_word(slot_a_sel)) begin
               sh_a_q <= {sh_a_q[30:0], din_now};
            end
            if (in_word(slot_b_sel)) begin
               sh_b_q <= {sh_b_q[30:0], din_now};
            end
         end
      end
   end

   // Bit about to be driven, counted from transmit slot 0; negative means
   // the offset has not yet elapsed. A new frame restarts the count, which
   // cuts any stream that would run past the frame end.
   wire [CNT_W+1:0] tx_base = frame_open ? '0 :
      (CNT_W+2)'(cnt_q) + 1'b1;
   wire [CNT_W+1:0] tx_pos_s = tx_base -
      (CNT_W+2)'(tx_offset);
   wire tx_before = tx_pos_s[CNT_W+1] || !framed_q;
   wire [CNT_W-3:0] tx_slot = tx_pos_s[CNT_W:3];
   wire [2:0] tx_bit = tx_pos_s[2:0];

   // Per-stream settings: slot field, enable and two-slot flag.
   wire [5:0] st_slot [tsp_pkg::STREAM_COUNT];
   wire st_en [tsp_pkg::STREAM_COUNT];
   wire st_two [tsp_pkg::STREAM_COUNT];
   wire [tsp_pkg::STREAM_COUNT-1:0] st_hit;
   wire [tsp_pkg::STREAM_COUNT-1:0] st_bit;

   // Streams 0 to 2 live in slot register A, 3 to 5 in slot register B.
   genvar gi;
   generate
      for (gi = 0; gi < tsp_pkg::STREAM_COUNT; gi++) begin : g_stream
         localparam int BASE = (gi % 3) * tsp_pkg::SLOT_FIELD_STRIDE;
         wire [31:0] reg_w = (gi < 3) ? slot_a_q : slot_b_q;
         wire hi_hit;
         wire lo_hit;
         assign st_slot[gi] = reg_w[BASE +: 6];
         assign st_en[gi] = reg_w[BASE + tsp_pkg::SLOT_EN_POS];
         // Sense and PDM always use two slots, battery as selected.
         assign st_two[gi] = (gi < 3) ? 1'b1 :
            (gi == 3) ? battery_slot_length : 1'b0;
         // Upper byte in the named slot, lower byte in the next one.
         assign hi_hit = (tx_slot == (CNT_W-2)'(st_slot[gi]));
         assign lo_hit = st_two[gi] &&
            (tx_slot == (CNT_W-2)'(st_slot[gi]) + 1'b1);
         assign st_hit[gi] = st_en[gi] && !tx_before &&
            (hi_hit || lo_hit);
         assign st_bit[gi] = hi_hit ? stream_q[gi][4'd15 - 4'(tx_bit)] :
            stream_q[gi][4'd7 - 4'(tx_bit)];
      end
   endgenerate

   // Overlap has no defined winner; overlapping bits are simply ORed.
   wire any_hit = |st_hit;
   wire hit_bit = |(st_hit & st_bit);

   // Stream words are latched at each frame opening so a frame carries a
   // consistent set of values.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < tsp_pkg::STREAM_COUNT; i++) begin
            stream_q[i] <= 16'h0000;
         end
      end else if (frame_open) begin
         stream_q[0] <= voltage_sense_data;
         stream_q[1] <= current_sense_data;
         stream_q[2] <= decimated_input_data;
         stream_q[3] <= {battery_data, 4'h0};
         stream_q[4] <= {temperature_data, 8'h00};
         stream_q[5] <= {gain_data, 8'h00};
      end
   end

   // Output pin: changes only at the chosen drive edge; unused bits give
   // zero or release the line as the fill setting asks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_q <= 1'b0;
         sdo_en_q <= 1'b0;
         keeper_q <= 1'b1;
      end else begin
         keeper_q <= tx_keeper;
         if (drive_edge) begin
            if (any_hit) begin
               sdo_q <= hit_bit;
               sdo_en_q <= 1'b1;
            end else begin
               sdo_q <= 1'b0;
               sdo_en_q <= !tx_fill;
            end
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign serial_data_out = sdo_q;
   assign serial_data_out_en = sdo_en_q;
   assign keeper_enable = keeper_q;
   assign play_sample = play_sample_q;
   assign play_valid = play_valid_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_fill_zero: assert property (
      drive_edge && !any_hit && !tx_fill |=> sdo_en_q && !sdo_q)
      else $error("zero fill not driven");
   chk_fill_float: assert property (
      drive_edge && !any_hit && tx_fill |=> !sdo_en_q)
      else $error("float fill still driven");
   chk_stream_gate: assert property (
      drive_edge && !(|st_hit) |=> !sdo_q)
      else $error("disabled stream sent data");
   chk_drive_edge: assert property (
      !drive_edge |=> $stable(sdo_q) && $stable(sdo_en_q))
      else $error("output moved off edge");
   chk_frame_open: assert property (
      frame_open && framed_q |=> cnt_q == '0 && play_valid_q)
      else $error("frame open lost");
   chk_null_sample: assert property (
      frame_open && framed_q && null_w |=> play_sample_q == 32'h0)
      else $error("null not muted");
   chk_mix_value: assert property (
      frame_open && framed_q && !null_w && mix_mode |=>
      play_sample_q == $past(mix_half)) else $error("mix value wrong");
   chk_keeper_follow: assert property (
      tx_keeper ##1 tx_keeper |-> keeper_enable)
      else $error("keeper not enabled");
   chk_offset_quiet: assert property (
      drive_edge && tx_before |=> !sdo_q)
      else $error("data before offset");
endmodule
